// *** common/cdcseq_pkg.sv ***
// constants, register map and carrier types for the conversion sequencer
// assumes a 25 MHz pclk and an APB slave with 32-bit data
package cdcseq_pkg;
	localparam int          CLK_HZ          = 25_000_000;
	localparam int          SAMPLE_HZ       = 250_000;
	localparam int          SAMPLE_CYC      = CLK_HZ / SAMPLE_HZ;
	localparam int          STAGE_US_256    = 3072;
	localparam int          FILTER_MULT     = 3;
	localparam int          WAKE_STEP_MS    = 200;
	localparam int          WAKE_STEP_CYC   = WAKE_STEP_MS * (CLK_HZ / 1000);
	localparam int          NUM_STAGES      = 8;
	localparam logic [11:0] OFS_CONTROL     = 12'h000;
	localparam logic [11:0] IDX_RESULT0     = 12'h00b;
	localparam logic [11:0] IDX_STAGE_CFG0  = 12'h020;
	localparam logic [11:0] IDX_SAMPLE_IN   = 12'h030;
	localparam logic [11:0] IDX_STATUS      = 12'h031;
	localparam int          DEC_LSB         = 8;
	localparam int          LAST_LSB        = 4;
	localparam int          WAKE_LSB        = 2;
	localparam int          MODE_LSB        = 0;
	localparam logic [15:0] CONTROL_RESET   = 16'h0000;
	localparam logic [1:0]  MODE_FULL       = 2'h0;
	localparam logic [1:0]  MODE_LOW        = 2'h2;

	// per-stage configuration as stored by software
	typedef struct packed {
		logic [1:0] input_sel;
		logic [5:0] minus_side_trim;
		logic [5:0] plus_side_trim;
	} cdcseq_stage_cfg_s;

	// what the front end is told for the current conversion
	typedef struct packed {
		logic [2:0]        stage;
		cdcseq_stage_cfg_s cfg;
	} cdcseq_fe_s;
endpackage : cdcseq_pkg

// *** hw/cdcseq_top.sv ***
// conversion sequencer with decimating averager and APB register file
// assumes modulator bit arrives from the analog domain, asynchronous to pclk
//
// The implementer's own choice: the APB interface to the registers.
module cdcseq_top
	import cdcseq_pkg::*;
#(
	parameter int STAGE_CYC_256 = STAGE_US_256 * (CLK_HZ / 1_000_000),
	parameter int WAKE_CYC      = WAKE_STEP_CYC
)(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  modulator_bit,
	output cdcseq_pkg::cdcseq_fe_s     front_end,
	output logic                       sample_strobe,
	output logic                       converting,
	output logic                       pair_plus_active,
	output logic                       pair_minus_active
);
	import cdcseq_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CONV  = 2'b01,
		ST_SLEEP = 2'b10
	} cdcseq_state_e;

	logic [15:0]       control;
	cdcseq_stage_cfg_s stage_cfg [NUM_STAGES];
	logic [15:0]       stage_result [NUM_STAGES];
	logic [15:0]       pair_level;
	cdcseq_state_e     state;
	logic [2:0]        stage;
	logic [31:0]       stage_cnt;
	logic [31:0]       wake_cnt;
	logic [7:0]        sample_div;
	logic [25:0]       acc;
	logic [9:0]        acc_cnt;
	logic              mod_meta;
	logic              mod_sync;
	logic [1:0]        mode;
	logic [2:0]        last_stage;
	logic [9:0]        ratio;
	logic [31:0]       stage_len;
	logic              stage_done;
	logic              wr_en;
	logic              ctrl_wr;
	logic [11:0]       idx;

	// ratio from the decimation field
	function automatic logic [9:0] dec_ratio(input logic [1:0] f);
		unique case (f)
			2'b00:   dec_ratio = 10'd256;
			2'b01:   dec_ratio = 10'd128;
			default: dec_ratio = 10'd64;
		endcase
	endfunction : dec_ratio

	assign mode       = control[MODE_LSB +: 2];
	assign last_stage = control[LAST_LSB +: 3];
	assign ratio      = dec_ratio(control[DEC_LSB +: 2]);
	// stage time scales with the ratio: 256 -> full, 128 -> half, 64 -> quarter
	assign stage_len  = STAGE_CYC_256 / (32'd256 / 32'(ratio));
	// a control write restarts the stage timer, so a shorter ratio never
	// leaves the counter beyond the new end point
	assign ctrl_wr    = wr_en && (idx == OFS_CONTROL);
	assign stage_done = (state == ST_CONV) && !ctrl_wr &&
		(stage_cnt == stage_len - 1);

	// two-stage synchroniser for the modulator bit
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mod_meta <= 1'b0;
			mod_sync <= 1'b0;
		end
		else
		begin
			mod_meta <= modulator_bit;
			mod_sync <= mod_meta;
		end

	// 250 kHz sample tick
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sample_div <= 8'h00;
		else if (state != ST_CONV || sample_div == 8'(SAMPLE_CYC - 1))
			sample_div <= 8'h00;
		else
			sample_div <= sample_div + 8'h01;
	assign sample_strobe = (state == ST_CONV) &&
		(sample_div == 8'(SAMPLE_CYC - 1));

	// sequencer: full power runs back to back, low power sleeps between runs
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			state     <= ST_IDLE;
			stage     <= 3'h0;
			stage_cnt <= 32'h0;
			wake_cnt  <= 32'h0;
		end
		else if (mode != MODE_FULL && mode != MODE_LOW)
		begin
			state     <= ST_IDLE;
			stage     <= 3'h0;
			stage_cnt <= 32'h0;
		end
		else
			unique case (state)
				ST_IDLE:
				begin
					state     <= ST_CONV;
					stage     <= 3'h0;
					stage_cnt <= 32'h0;
				end
				ST_CONV:
					if (ctrl_wr)
						stage_cnt <= 32'h0;
					else if (stage_done)
					begin
						stage_cnt <= 32'h0;
						if (stage != last_stage)
							stage <= stage + 3'h1;
						else if (mode == MODE_LOW)
						begin
							state    <= ST_SLEEP;
							wake_cnt <= 32'h0;
						end
						else
							stage <= 3'h0;
					end
					else
						stage_cnt <= stage_cnt + 32'h1;
				ST_SLEEP:
					if (mode == MODE_FULL ||
						wake_cnt == WAKE_CYC * (32'(control[WAKE_LSB +: 2]) + 1) - 1)
					begin
						state     <= ST_CONV;
						stage     <= 3'h0;
						stage_cnt <= 32'h0;
					end
					else
						wake_cnt <= wake_cnt + 32'h1;
				default:
					state <= ST_IDLE;
			endcase

	assign converting = (state == ST_CONV);

	// front end gets this stage's own input and trim settings
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			front_end <= '0;
		else
		begin
			front_end.stage <= stage;
			front_end.cfg   <= stage_cfg[stage];
		end

	// averager: sums at most 3*ratio samples (3*ratio-1 at the default stage time), result is the mean scaled to 16 bits
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			acc     <= 26'h0;
			acc_cnt <= 10'h0;
		end
		else if (state != ST_CONV || stage_done || ctrl_wr)
		begin
			acc     <= 26'h0;
			acc_cnt <= 10'h0;
		end
		else if (sample_strobe && acc_cnt < 10'(FILTER_MULT) * ratio)
		begin
			acc     <= acc + (mod_sync ? 26'h0ffff : 26'h0);
			acc_cnt <= acc_cnt + 10'h1;
		end

	// store result at end of stage
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			for (int i = 0; i < NUM_STAGES; i++)
				stage_result[i] <= 16'h0000;
		else if (stage_done)
			stage_result[stage] <= (acc_cnt == 10'h0) ? 16'h0000 :
				16'(acc / 26'(acc_cnt));

	// differential pair: positive swing vs negative swing on stage 0
	always_comb
	begin
		pair_plus_active  = 1'b0;
		pair_minus_active = 1'b0;
		if (stage_result[0] > pair_level + 16'h1000)
			pair_plus_active = 1'b1;
		else if (stage_result[0] < pair_level - 16'h1000)
			pair_minus_active = 1'b1;
	end

	// APB register file, zero wait states
	assign idx     = paddr >> 2;
	assign wr_en   = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			control    <= CONTROL_RESET;
			pair_level <= 16'h8000;
			for (int i = 0; i < NUM_STAGES; i++)
				stage_cfg[i] <= '0;
		end
		else if (wr_en)
		begin
			if (idx == OFS_CONTROL)
				control <= pwdata[15:0];
			else if (idx == IDX_SAMPLE_IN)
				pair_level <= pwdata[15:0];
			else if (idx >= IDX_STAGE_CFG0 &&
				idx < IDX_STAGE_CFG0 + 12'(NUM_STAGES))
				stage_cfg[3'(idx - IDX_STAGE_CFG0)] <= pwdata[13:0];
		end

	// read mux
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
		begin
			prdata <= 32'h0;
			if (idx == OFS_CONTROL)
				prdata <= {16'h0, control};
			else if (idx >= IDX_RESULT0 &&
				idx < IDX_RESULT0 + 12'(NUM_STAGES))
				prdata <= {16'h0, stage_result[3'(idx - IDX_RESULT0)]};
			else if (idx >= IDX_STAGE_CFG0 &&
				idx < IDX_STAGE_CFG0 + 12'(NUM_STAGES))
				prdata <= {18'h0, stage_cfg[3'(idx - IDX_STAGE_CFG0)]};
			else if (idx == IDX_SAMPLE_IN)
				prdata <= {16'h0, pair_level};
			else if (idx == IDX_STATUS)
				prdata <= {27'h0, state == ST_SLEEP, converting, stage};
		end

	// sequence starts at zero after the last stage in full power
	sequence last_done_s;
		stage_done && stage == last_stage && mode == MODE_FULL;
	endsequence
	wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		last_done_s |=> stage == 3'h0)
		else $error("sequence did not restart at stage zero");
	stage_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		stage_done && stage != last_stage && mode[0] == 1'b0 |=>
		stage == $past(stage) + 3'h1)
		else $error("stage did not advance by one");
	shutdown_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode[0] |=> state == ST_IDLE)
		else $error("shutdown did not stop the sequencer");
	ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
		control[9] |-> ratio == 10'd64)
		else $error("ratio decode wrong");
	samples_a: assert property (@(posedge pclk) disable iff (!presetn)
		acc_cnt <= 10'(FILTER_MULT) * ratio)
		else $error("too many samples averaged");
	stage_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		stage_cnt < stage_len)
		else $error("stage overran its time");
	sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
		stage_done && stage == last_stage && mode == MODE_LOW |=>
		state == ST_SLEEP)
		else $error("low power did not sleep after sequence");
	pair_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(pair_plus_active && pair_minus_active))
		else $error("both buttons of a pair active");
endmodule : cdcseq_top

// *** testbench/cdcseq_modulator_model.sv ***
// behavioural modulator stream feeding the conversion sequencer
// assumes the bench supplies pclk and picks the bit density by level
module cdcseq_modulator_model
(
	input  wire logic pclk,
	input  wire logic level,
	output logic      modulator_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	initial modulator_bit = 1'b0;
	// one modulator bit each clock, changed just after the edge
	always @(posedge pclk)
		modulator_bit <= level;
endmodule : cdcseq_modulator_model

// *** testbench/testbench.sv ***
// self-checking bench for the conversion sequencer over APB
// assumes short stage and wake counts set through the top's parameters
module testbench;
	import cdcseq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        level = 1, pready, pslverr, modulator_bit;
	logic        sample_strobe, converting, pp, pm;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	cdcseq_fe_s  front_end;
	int          num_errors = 0, check_count = 0;
	cdcseq_top #(.STAGE_CYC_256(4096), .WAKE_CYC(50)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .modulator_bit(modulator_bit),
		.front_end(front_end), .sample_strobe(sample_strobe),
		.converting(converting), .pair_plus_active(pp),
		.pair_minus_active(pm));
	cdcseq_modulator_model sensor (.pclk(pclk), .level(level),
		.modulator_bit(modulator_bit));
	// free-running 25 MHz clock
	always #20 pclk = ~pclk;
	task check_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val
	task stop_test;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// one APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		{psel, penable} <= 2'b00;
	endtask : apb
	// cycles until the front end shows a new stage
	task next_stage(output int n);
		logic [2:0] s;
		s = front_end.stage;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (front_end.stage === s && n < 9000);
	endtask : next_stage
	task to_stage(input logic [2:0] s, output int n);
		do
			next_stage(n);
		while (front_end.stage !== s);
	endtask : to_stage
	// cycles until converting takes the given level
	task wait_lvl(input logic v, output int n);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (converting !== v && n < 20000);
	endtask : wait_lvl
	task t_reset;
		apb(1'b0, OFS_CONTROL, 32'h0);
		check_val(rd, 32'h0);
		apb(1'b1, 12'hffc, 32'h1234);
		apb(1'b0, 12'hffc, 32'h0);
		check_val(rd, 32'h0);
	endtask : t_reset
	// stage order, per-stage time and back-to-back restart
	task t_seq(input logic [1:0] dec, input logic [3:0] last, input int cyc);
		int n;
		apb(1'b1, OFS_CONTROL, {22'h0, dec, last, 4'h0});
		to_stage(3'h0, n);
		for (int s = 1; s <= last[2:0] + 1; s++)
		begin
			next_stage(n);
			check_val(front_end.stage, 3'(s % (last[2:0] + 1)));
			check_val(n, cyc);
		end
	endtask : t_seq
	task t_results;
		for (int s = 0; s < 8; s++)
		begin
			apb(1'b0, (IDX_RESULT0 + 12'(s)) << 2, 32'h0);
			check_val(rd, 32'hffff);
		end
		check_val({pp, pm}, 2'b10);
		check_val(pslverr, 1'b0);
	endtask : t_results
	task t_cfg;
		int n;
		apb(1'b1, (IDX_STAGE_CFG0 + 12'h1) << 2, 32'h1a95);
		to_stage(3'h0, n);
		to_stage(3'h1, n);
		check_val(front_end.cfg, 14'h1a95);
	endtask : t_cfg
	// sleep of (field+1) wake steps, then one 1024-cycle sequence
	task t_low;
		int n;
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, OFS_CONTROL, {22'h0, 2'h3, 4'h0, 2'(k), 2'h2});
			wait_lvl(1'b1, n);
			wait_lvl(1'b0, n);
			wait_lvl(1'b1, n);
			check_val(n, (k + 1) * 50);
			wait_lvl(1'b0, n);
			check_val(n, 1024);
		end
	endtask : t_low
	task t_off;
		int n;
		int cnt;
		for (int m = 1; m < 4; m += 2)
		begin
			apb(1'b1, OFS_CONTROL, 32'(m));
			wait_lvl(1'b0, n);
			repeat (2000) @(posedge pclk);
			check_val(converting, 1'b0);
			apb(1'b1, OFS_CONTROL, 32'h0);
			wait_lvl(1'b1, n);
			check_val(converting, 1'b1);
			cnt = 0;
			repeat (1000)
			begin
				@(posedge pclk);
				if (sample_strobe === 1'b1)
					cnt++;
			end
			check_val(cnt, 1000 / SAMPLE_CYC);
		end
	endtask : t_off
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_seq(2'h0, 4'h1, 4096);
		t_seq(2'h1, 4'h2, 2048);
		t_seq(2'h2, 4'h3, 1024);
		t_seq(2'h3, 4'h7, 1024);
		t_results;
		t_cfg;
		t_low;
		t_off;
		stop_test;
	end
	// watchdog a little beyond the expected run of about 3.4 ms
	initial
	begin
		#3_800_000;
		num_errors++;
		stop_test;
	end
endmodule : testbench
